/* File: hdl/flic_pkg.sv */
// Constants, field layout and carrier types of the four-level interrupt controller.
// Assumes a single 100 MHz system clock shared with the CPU core.
package flic_pkg;

	localparam int          NUM_SRC   = 24;
	localparam int          NUM_EXT   = 4;
	localparam int          CLK_MHZ   = 100;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_TIMER_AND_EXT_INT_CONTROL  = 8'h88;
	localparam logic [7:0]  IDX_AUX0  = 8'ha1;
	localparam logic [7:0]  IDX_EXTENDED_ENABLE_TWO  = 8'ha5;
	localparam logic [7:0]  IDX_EP2L  = 8'ha6;
	localparam logic [7:0]  IDX_EP2H  = 8'ha7;
	localparam logic [7:0]  IDX_MIE   = 8'ha8;
	localparam logic [7:0]  IDX_EXTENDED_ENABLE_ONE  = 8'had;
	localparam logic [7:0]  IDX_EP1L  = 8'hae;
	localparam logic [7:0]  IDX_EP1H  = 8'haf;
	localparam logic [7:0]  IDX_P0H   = 8'hb7;
	localparam logic [7:0]  IDX_P0L   = 8'hb8;
	localparam logic [7:0]  IDX_XCON  = 8'hc0;

	// Reset values
	localparam logic [7:0]  RST_REG   = 8'h00;

	// Main enable fields
	localparam int          MIE_GLOBAL = 7;
	localparam int          MIE_RSVD   = 6;

	// Timer and external 0/1 control fields
	localparam int          TC_TYPE0  = 0;
	localparam int          TC_FLAG0  = 1;
	localparam int          TC_TYPE1  = 2;
	localparam int          TC_FLAG1  = 3;
	localparam int          TC_RUN0   = 4;
	localparam int          TC_TF0    = 5;
	localparam int          TC_RUN1   = 6;
	localparam int          TC_TF1    = 7;

	// Auxiliary control fields
	localparam int          AX_POL0   = 0;
	localparam int          AX_POL1   = 1;

	// External 2/3 control fields
	localparam int          XC_TYPE2  = 0;
	localparam int          XC_FLAG2  = 1;
	localparam int          XC_EN2    = 2;
	localparam int          XC_POL2   = 3;
	localparam int          XC_TYPE3  = 4;
	localparam int          XC_FLAG3  = 5;
	localparam int          XC_EN3    = 6;
	localparam int          XC_POL3   = 7;

	// Source positions (zero based) with hardware-owned flags
	localparam int          SRC_EXT0  = 0;
	localparam int          SRC_TMR0  = 1;
	localparam int          SRC_EXT1  = 2;
	localparam int          SRC_TMR1  = 3;
	localparam int          SRC_EXT2  = 6;
	localparam int          SRC_EXT3  = 7;

	// Vector of source n is base plus n times step
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam logic [15:0] VEC_STEP  = 16'h0008;

	typedef struct packed {
		logic [4:0]  src;
		logic [1:0]  level;
		logic [15:0] vector;
	} flic_call_s;

endpackage

/* File: hdl/flic_top.sv */
// Four-level interrupt controller: enables, priority ranking, polling and vector call.
// Assumes the CPU sequencer flags the final cycle of each instruction and RETI, and
// that peripheral request levels are synchronous to i_clk.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module flic_top (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// Avalon-MM slave
	input  wire logic [9:0]           i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [31:0]          i_avs_writedata,
	input  wire logic [3:0]           i_avs_byteenable,
	output logic                      o_avs_waitrequest,
	output logic [31:0]               o_avs_readdata,
	// Sources and pins
	input  wire logic [3:0]           i_ext_irq_pin,
	input  wire logic [1:0]           i_timer_ovf,
	input  wire logic [17:0]          i_periph_req,
	// CPU sequencer
	input  wire logic                 i_instr_last,
	input  wire logic                 i_instr_reti,
	input  wire logic                 i_sleep,
	output logic                      o_call,
	output flic_pkg::flic_call_s      o_call_info,
	output logic                      o_wake,
	output logic [3:0]                o_level_active,
	output logic [1:0]                o_timer_run,
	output logic [5:0]                o_aux_misc
);
	import flic_pkg::*;

	////////////////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]          timer_and_ext_int_control_q,    timer_and_ext_int_control_d;
	logic [7:0]          aux0_q,    aux0_d;
	logic [7:0]          mie_q,     mie_d;
	logic [7:0]          xcon_q,    xcon_d;
	logic [7:0]          extended_enable_one_q,    extended_enable_one_d;
	logic [7:0]          extended_enable_two_q,    extended_enable_two_d;
	logic [7:0]          p0l_q,     p0l_d;
	logic [7:0]          p0h_q,     p0h_d;
	logic [7:0]          p1l_q,     p1l_d;
	logic [7:0]          p1h_q,     p1h_d;
	logic [7:0]          p2l_q,     p2l_d;
	logic [7:0]          p2h_q,     p2h_d;
	logic [3:0]          asrt_q,    asrt_d;
	logic [23:0]         samp_q,    samp_d;
	logic [3:0]          active_q,  active_d;
	logic                hold_q,    hold_d;
	logic                call_q,    call_d;
	flic_call_s          info_q,    info_d;
	logic                wake_q,    wake_d;
	logic                wait_q,    wait_d;
	logic [31:0]         rdata_q,   rdata_d;

	////////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic [7:0]          bus_idx;
	logic                wr_fire;
	logic                prot_wr;
	logic [7:0]          wdat;

	assign bus_idx = i_avs_address[9:2];
	assign wdat    = i_avs_writedata[7:0];
	// Write lands only at the edge where waitrequest is seen low
	assign wr_fire = i_avs_write & ~wait_q & i_avs_byteenable[0];

	always_comb begin
		unique case (bus_idx)
			IDX_MIE, IDX_P0L, IDX_P0H, IDX_EXTENDED_ENABLE_ONE, IDX_EP1L,
			IDX_EP1H, IDX_EXTENDED_ENABLE_TWO, IDX_EP2L, IDX_EP2H, IDX_XCON: prot_wr = wr_fire;
			default: prot_wr = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////
	// External inputs

	logic [3:0]          pol;
	logic [3:0]          typ;
	logic [3:0]          asrt;
	logic [3:0]          hit;

	assign pol = {xcon_q[XC_POL3], xcon_q[XC_POL2], aux0_q[AX_POL1], aux0_q[AX_POL0]};
	assign typ = {xcon_q[XC_TYPE3], xcon_q[XC_TYPE2], timer_and_ext_int_control_q[TC_TYPE1], timer_and_ext_int_control_q[TC_TYPE0]};

	genvar gx;
	generate
		for (gx = 0; gx < NUM_EXT; gx++) begin : g_ext
			assign asrt[gx] = ~(i_ext_irq_pin[gx] ^ pol[gx]);
			assign hit[gx]  = typ[gx] ? (asrt[gx] & ~asrt_q[gx]) : asrt[gx];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////
	// Request, enable and priority vectors

	logic [23:0]         req;
	logic [23:0]         en;
	logic [23:0]         pr_hi;
	logic [23:0]         pr_lo;

	assign req = {i_periph_req[17:2], xcon_q[XC_FLAG3], xcon_q[XC_FLAG2],
	              i_periph_req[1:0], timer_and_ext_int_control_q[TC_TF1], timer_and_ext_int_control_q[TC_FLAG1],
	              timer_and_ext_int_control_q[TC_TF0], timer_and_ext_int_control_q[TC_FLAG0]};
	assign en  = {extended_enable_two_q, extended_enable_one_q, xcon_q[XC_EN3], xcon_q[XC_EN2], mie_q[5:0]};
	assign pr_hi = {p2h_q, p1h_q, p0h_q};
	assign pr_lo = {p2l_q, p1l_q, p0l_q};

	////////////////////////////////////////////////////////////////////////////////////
	// Arbitration

	logic [23:0]         cand;
	logic                found;
	logic [4:0]          win;
	logic [1:0]          win_lvl;
	logic [3:0]          ge_mask;
	logic                take;
	logic [23:0]         clr_src;

	// Polls last cycle's samples, gated by the current enables
	assign cand = samp_q & en & {NUM_SRC{mie_q[MIE_GLOBAL]}};

	always_comb begin
		found   = 1'b0;
		win     = 5'h00;
		win_lvl = 2'h0;
		// Descending scan so the lowest source number wins a tie
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (cand[i] && (!found || {pr_hi[i], pr_lo[i]} >= win_lvl)) begin
				found   = 1'b1;
				win     = 5'(i);
				win_lvl = {pr_hi[i], pr_lo[i]};
			end
		end
	end

	always_comb begin
		unique case (win_lvl)
			2'h0: ge_mask = 4'hf;
			2'h1: ge_mask = 4'he;
			2'h2: ge_mask = 4'hc;
			2'h3: ge_mask = 4'h8;
		endcase
	end

	assign take = found
	            & ~|(active_q & ge_mask)
	            & i_instr_last
	            & ~hold_q & ~prot_wr & ~i_instr_reti;

	assign clr_src = take ? (24'h000001 << win) : 24'h000000;

	////////////////////////////////////////////////////////////////////////////////////
	// Register next state

	always_comb begin
		timer_and_ext_int_control_d = timer_and_ext_int_control_q;
		aux0_d = aux0_q;
		mie_d  = mie_q;
		xcon_d = xcon_q;
		extended_enable_one_d = extended_enable_one_q;
		extended_enable_two_d = extended_enable_two_q;
		p0l_d  = p0l_q;
		p0h_d  = p0h_q;
		p1l_d  = p1l_q;
		p1h_d  = p1h_q;
		p2l_d  = p2l_q;
		p2h_d  = p2h_q;
		if (wr_fire) begin
			unique case (bus_idx)
				IDX_TIMER_AND_EXT_INT_CONTROL: timer_and_ext_int_control_d = wdat;
				IDX_AUX0: aux0_d = wdat;
				IDX_MIE:  mie_d  = wdat & ~(8'h01 << MIE_RSVD);
				IDX_XCON: xcon_d = wdat;
				IDX_EXTENDED_ENABLE_ONE: extended_enable_one_d = wdat;
				IDX_EXTENDED_ENABLE_TWO: extended_enable_two_d = wdat;
				IDX_P0L:  p0l_d  = wdat;
				IDX_P0H:  p0h_d  = wdat;
				IDX_EP1L: p1l_d  = wdat;
				IDX_EP1H: p1h_d  = wdat;
				IDX_EP2L: p2l_d  = wdat;
				IDX_EP2H: p2h_d  = wdat;
				default: ;
			endcase
		end
		// Service start clears timer flags and edge-mode external flags
		if (clr_src[SRC_TMR0]) timer_and_ext_int_control_d[TC_TF0] = 1'b0;
		if (clr_src[SRC_TMR1]) timer_and_ext_int_control_d[TC_TF1] = 1'b0;
		if (clr_src[SRC_EXT0] && typ[0]) timer_and_ext_int_control_d[TC_FLAG0] = 1'b0;
		if (clr_src[SRC_EXT1] && typ[1]) timer_and_ext_int_control_d[TC_FLAG1] = 1'b0;
		if (clr_src[SRC_EXT2] && typ[2]) xcon_d[XC_FLAG2] = 1'b0;
		if (clr_src[SRC_EXT3] && typ[3]) xcon_d[XC_FLAG3] = 1'b0;
		// Hardware set last so a same-cycle clear never loses an event
		if (i_timer_ovf[0]) timer_and_ext_int_control_d[TC_TF0] = 1'b1;
		if (i_timer_ovf[1]) timer_and_ext_int_control_d[TC_TF1] = 1'b1;
		if (typ[0]) timer_and_ext_int_control_d[TC_FLAG0] = timer_and_ext_int_control_d[TC_FLAG0] | hit[0];
		else        timer_and_ext_int_control_d[TC_FLAG0] = asrt[0];
		if (typ[1]) timer_and_ext_int_control_d[TC_FLAG1] = timer_and_ext_int_control_d[TC_FLAG1] | hit[1];
		else        timer_and_ext_int_control_d[TC_FLAG1] = asrt[1];
		if (typ[2]) xcon_d[XC_FLAG2] = xcon_d[XC_FLAG2] | hit[2];
		else        xcon_d[XC_FLAG2] = asrt[2];
		if (typ[3]) xcon_d[XC_FLAG3] = xcon_d[XC_FLAG3] | hit[3];
		else        xcon_d[XC_FLAG3] = asrt[3];
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			timer_and_ext_int_control_q <= RST_REG;
			aux0_q <= RST_REG;
			mie_q  <= RST_REG;
			xcon_q <= RST_REG;
			extended_enable_one_q <= RST_REG;
			extended_enable_two_q <= RST_REG;
			p0l_q  <= RST_REG;
			p0h_q  <= RST_REG;
			p1l_q  <= RST_REG;
			p1h_q  <= RST_REG;
			p2l_q  <= RST_REG;
			p2h_q  <= RST_REG;
		end else begin
			timer_and_ext_int_control_q <= timer_and_ext_int_control_d;
			aux0_q <= aux0_d;
			mie_q  <= mie_d;
			xcon_q <= xcon_d;
			extended_enable_one_q <= extended_enable_one_d;
			extended_enable_two_q <= extended_enable_two_d;
			p0l_q  <= p0l_d;
			p0h_q  <= p0h_d;
			p1l_q  <= p1l_d;
			p1h_q  <= p1h_d;
			p2l_q  <= p2l_d;
			p2h_q  <= p2h_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Sequencing: samples, service levels, hold-off, call and wake

	logic [3:0]          top_bit;

	// Highest level in service, cleared by RETI
	assign top_bit = active_q[3] ? 4'h8 : active_q[2] ? 4'h4 : active_q[1] ? 4'h2 :
	                 active_q[0] ? 4'h1 : 4'h0;

	always_comb begin
		asrt_d   = asrt;
		samp_d   = req;
		active_d = active_q;
		if (i_instr_last && i_instr_reti) begin
			active_d = active_q & ~top_bit;
		end
		if (take) begin
			active_d = active_d | (4'h1 << win_lvl);
		end
		// Cleared once the current instruction completes
		hold_d = (hold_q | prot_wr) & ~i_instr_last;
		if (i_instr_reti && !i_instr_last) begin
			hold_d = hold_q | prot_wr;
		end
		call_d        = take;
		info_d        = info_q;
		if (take) begin
			info_d.src    = win;
			info_d.level  = win_lvl;
			info_d.vector = 16'(VEC_BASE + VEC_STEP * {11'h000, win});
		end
		// Sleep wake from ext 2/3 only when enabled
		wake_d = i_sleep & ((hit[2] & xcon_q[XC_EN2]) | (hit[3] & xcon_q[XC_EN3]));
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			asrt_q   <= 4'h0;
			samp_q   <= 24'h000000;
			active_q <= 4'h0;
			hold_q   <= 1'b0;
			call_q   <= 1'b0;
			info_q   <= '0;
			wake_q   <= 1'b0;
		end else begin
			asrt_q   <= asrt_d;
			samp_q   <= samp_d;
			active_q <= active_d;
			hold_q   <= hold_d;
			call_q   <= call_d;
			info_q   <= info_d;
			wake_q   <= wake_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Avalon answer: one wait cycle, read data loaded while waiting

	always_comb begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if ((i_avs_read || i_avs_write) && wait_q) begin
			wait_d  = 1'b0;
			rdata_d = 32'h00000000;
			unique case (bus_idx)
				IDX_TIMER_AND_EXT_INT_CONTROL: rdata_d[7:0] = timer_and_ext_int_control_q;
				IDX_AUX0: rdata_d[7:0] = aux0_q;
				IDX_MIE:  rdata_d[7:0] = mie_q & ~(8'h01 << MIE_RSVD);
				IDX_XCON: rdata_d[7:0] = xcon_q;
				IDX_EXTENDED_ENABLE_ONE: rdata_d[7:0] = extended_enable_one_q;
				IDX_EXTENDED_ENABLE_TWO: rdata_d[7:0] = extended_enable_two_q;
				IDX_P0L:  rdata_d[7:0] = p0l_q;
				IDX_P0H:  rdata_d[7:0] = p0h_q;
				IDX_EP1L: rdata_d[7:0] = p1l_q;
				IDX_EP1H: rdata_d[7:0] = p1h_q;
				IDX_EP2L: rdata_d[7:0] = p2l_q;
				IDX_EP2H: rdata_d[7:0] = p2h_q;
				default:  rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata    = rdata_q;
	assign o_call            = call_q;
	assign o_call_info       = info_q;
	assign o_wake            = wake_q;
	assign o_level_active    = active_q;
	assign o_timer_run       = {timer_and_ext_int_control_q[TC_RUN1], timer_and_ext_int_control_q[TC_RUN0]};
	assign o_aux_misc        = aux0_q[7:2];

endmodule

`default_nettype wire

/* File: testbench/flic_monitor.sv */
// Port checker for the four-level interrupt controller.
// Bound to flic_top from the testbench top file; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module flic_monitor (
	input wire logic                 i_clk,
	input wire logic                 i_rst,
	input wire logic [9:0]           i_avs_address,
	input wire logic                 i_avs_read,
	input wire logic                 i_avs_write,
	input wire logic                 o_avs_waitrequest,
	input wire logic [31:0]          o_avs_readdata,
	input wire logic                 i_instr_last,
	input wire logic                 i_instr_reti,
	input wire logic                 i_sleep,
	input wire logic                 o_call,
	input wire flic_pkg::flic_call_s o_call_info,
	input wire logic                 o_wake,
	input wire logic [3:0]           o_level_active
);
	import flic_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_wait_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("bus request not answered");
	chk_mie_rsvd: assert property (i_avs_read && !o_avs_waitrequest &&
		i_avs_address[9:2] == IDX_MIE |-> o_avs_readdata[31:6] == 26'h0 ||
		(o_avs_readdata[6] == 1'b0 && o_avs_readdata[31:8] == 24'h0))
		else $error("main enable read shows reserved bit");
	chk_call_last: assert property (o_call |-> $past(i_instr_last))
		else $error("call outside final instruction cycle");
	chk_call_reti: assert property (o_call |-> !$past(i_instr_reti))
		else $error("call during return instruction");
	chk_call_level: assert property (o_call |-> o_level_active[o_call_info.level] &&
		($past(o_level_active) >> o_call_info.level) == 4'h0)
		else $error("call while equal or higher level active");
	chk_vector_map: assert property (o_call |-> o_call_info.vector ==
		VEC_BASE + VEC_STEP * {11'h0, o_call_info.src}) else $error("bad vector");
	chk_reti_drop: assert property ($past(i_instr_reti && i_instr_last) &&
		$past(o_level_active) != 4'h0 |-> $countones(o_level_active) + 1 ==
		$countones($past(o_level_active))) else $error("return did not end one level");
	chk_wake_sleep: assert property (o_wake |-> $past(i_sleep))
		else $error("wake while not asleep");
	chk_call_reset: assert property (o_call |-> !$past(i_rst) && !$past(i_rst, 2))
		else $error("call too soon after reset");
	cover property (o_call && o_call_info.level == 2'b11);
	cover property (o_call && o_call_info.src == 5'd6);
	cover property (o_wake);
endmodule
`default_nettype wire

/* File: testbench/flic_cpu_model.sv */
// Instruction sequencer stand-in: fixed-length instructions, RETI on request.
// A request is taken at any edge; the RETI runs as the next whole instruction.
`timescale 1ns/1ps
`default_nettype none
module flic_cpu_model #(
	parameter int LEN = 3
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reti_req,
	output logic     o_instr_last,
	output logic     o_instr_reti
);
	int   cnt_q;
	logic pend_q;
	logic reti_q;
	assign o_instr_last = (cnt_q == LEN - 1);
	assign o_instr_reti = reti_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q  <= 0;
			pend_q <= 1'b0;
			reti_q <= 1'b0;
		end else begin
			cnt_q <= o_instr_last ? 0 : cnt_q + 1;
			if (i_reti_req)
				pend_q <= 1'b1;
			// Held for the whole RETI so the hold spans it
			if (o_instr_last) begin
				reti_q <= pend_q | i_reti_req;
				pend_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for flic_top with a sequencer model on the core side.
// Peripheral requests and pins are driven directly by the bench.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
	import flic_pkg::*;
	logic        clk, rst, rd, wr, last, reti, sleep, reti_req, call, wake, waitr;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata;
	logic [3:0]  be, pins, lvl;
	logic [1:0]  tovf, trun;
	logic [17:0] preq;
	logic [5:0]  amisc;
	flic_call_s  info, got;
	logic        hit;
	int          bad_count, cmp_count, cyc;
	flic_top flic_top_i (.i_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_waitrequest(waitr), .o_avs_readdata(rdata), .i_ext_irq_pin(pins),
		.i_timer_ovf(tovf), .i_periph_req(preq), .i_instr_last(last), .i_instr_reti(reti),
		.i_sleep(sleep), .o_call(call), .o_call_info(info), .o_wake(wake),
		.o_level_active(lvl), .o_timer_run(trun), .o_aux_misc(amisc));
	flic_cpu_model flic_cpu_model_i (.i_clk(clk), .i_rst(rst), .i_reti_req(reti_req),
		.o_instr_last(last), .o_instr_reti(reti));
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		addr <= {idx, 2'b00}; wdata <= {24'h0, d}; rd <= !w; wr <= w;
		do @(posedge clk); while (waitr !== 1'b0);
		q = rdata[7:0];
		rd <= 1'b0; wr <= 1'b0;
	endtask
	task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'b1, idx, d, x);
	endtask
	task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] x;
		bus(1'b0, idx, 8'h00, x);
		`CHK(n, e, x)
	endtask
	// Watches call when sel is 0, wake otherwise
	task automatic waitev(input int n, input logic sel);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++) begin
			@(posedge clk);
			if ((sel ? wake : call) === 1'b1) begin hit = 1'b1; got = info; end
		end
	endtask
	task automatic do_reti();
		@(posedge clk) reti_req <= 1'b1;
		@(posedge clk) reti_req <= 1'b0;
		for (int i = 0; i < 20 && !(reti === 1'b1 && last === 1'b1); i++) @(posedge clk);
		@(posedge clk);
	endtask
	task automatic edge_pin(input int p);
		@(posedge clk) pins[p] <= 1'b0;
		@(posedge clk) pins[p] <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rchk("timer_and_ext_int_control", IDX_TIMER_AND_EXT_INT_CONTROL, 8'h00);
		rchk("mie", IDX_MIE, 8'h00);
		rchk("p1h", IDX_EP1H, 8'h00);
		rchk("xcon", IDX_XCON, 8'h00);
		wreg(IDX_EXTENDED_ENABLE_TWO, 8'h5a); rchk("extended_enable_two", IDX_EXTENDED_ENABLE_TWO, 8'h5a);
		wreg(8'h10, 8'hff); rchk("unmapped", 8'h10, 8'h00);
		wreg(IDX_TIMER_AND_EXT_INT_CONTROL, 8'h50); @(posedge clk);
		`CHK("timer run", 2'b11, trun)
		wreg(IDX_TIMER_AND_EXT_INT_CONTROL, 8'h00); wreg(IDX_AUX0, 8'hfc); @(posedge clk);
		`CHK("aux misc", 6'h3f, amisc)
		wreg(IDX_AUX0, 8'h00);
		// Reserved bit 6 always written as zero
		wreg(IDX_MIE, 8'h3f); rchk("mie wr", IDX_MIE, 8'h3f);
		wreg(IDX_MIE, 8'h00); wreg(IDX_EXTENDED_ENABLE_TWO, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_mask();
		wreg(IDX_MIE, 8'h80);
		@(posedge clk) preq <= 18'h4;
		waitev(30, 1'b0); `CHK("src disabled", 1'b0, hit)
		wreg(IDX_MIE, 8'h00); wreg(IDX_EXTENDED_ENABLE_ONE, 8'h01);
		waitev(30, 1'b0); `CHK("global off", 1'b0, hit)
		wreg(IDX_MIE, 8'h80);
		waitev(30, 1'b0); `CHK("call", 1'b1, hit)
		`CHK("vector", 16'h0043, got.vector)
		`CHK("active", 4'h1, lvl)
		@(posedge clk) preq <= 18'h0;
		do_reti(); `CHK("active off", 4'h0, lvl)
		$display("test mask done");
	endtask
	task automatic t_prio();
		wreg(IDX_EXTENDED_ENABLE_ONE, 8'h03);
		for (int lv = 0; lv < 4; lv++) begin
			wreg(IDX_EP1H, {6'h0, lv[1], 1'b0});
			wreg(IDX_EP1L, {6'h0, lv[0], 1'b0});
			@(posedge clk) preq <= 18'hc;
			waitev(30, 1'b0); `CHK("prio call", 1'b1, hit)
			`CHK("winner", (lv == 0) ? 5'd8 : 5'd9, got.src)
			`CHK("level", 2'(lv), got.level)
			waitev(15, 1'b0); `CHK("no preempt", 1'b0, hit)
			@(posedge clk) preq <= 18'h0;
			do_reti();
		end
		wreg(IDX_EXTENDED_ENABLE_ONE, 8'h00); wreg(IDX_EP1H, 8'h00); wreg(IDX_EP1L, 8'h00);
		$display("test prio done");
	endtask
	task automatic t_ext();
		// Pin parked inactive first so the polarity change makes no edge
		@(posedge clk) pins[2] <= 1'b0;
		wreg(IDX_XCON, 8'h0d);
		edge_pin(2);
		waitev(30, 1'b0); `CHK("ext2 src", 5'd6, got.src)
		rchk("flag2 clr", IDX_XCON, 8'h0d);
		waitev(20, 1'b0); `CHK("steady pin", 1'b0, hit)
		do_reti();
		@(posedge clk) pins[0] <= 1'b0;
		rchk("lvl flag", IDX_TIMER_AND_EXT_INT_CONTROL, 8'h02);
		@(posedge clk) pins[0] <= 1'b1;
		rchk("lvl gone", IDX_TIMER_AND_EXT_INT_CONTROL, 8'h00);
		wreg(IDX_AUX0, 8'h01); rchk("high lvl", IDX_TIMER_AND_EXT_INT_CONTROL, 8'h02);
		wreg(IDX_AUX0, 8'h00); wreg(IDX_XCON, 8'h00); wreg(IDX_MIE, 8'h00);
		$display("test ext done");
	endtask
	task automatic t_soft();
		wreg(IDX_XCON, 8'h70); wreg(IDX_XCON, 8'h50); wreg(IDX_MIE, 8'h80);
		waitev(30, 1'b0); `CHK("sw cancel", 1'b0, hit)
		wreg(IDX_XCON, 8'h70);
		waitev(30, 1'b0); `CHK("sw raise", 16'h003b, got.vector)
		rchk("flag3 clr", IDX_XCON, 8'h50);
		do_reti(); wreg(IDX_MIE, 8'h00); wreg(IDX_XCON, 8'h00);
		$display("test soft done");
	endtask
	task automatic t_wake();
		@(posedge clk) sleep <= 1'b1;
		wreg(IDX_XCON, 8'h09); edge_pin(2);
		waitev(6, 1'b1); `CHK("wake off", 1'b0, hit)
		wreg(IDX_XCON, 8'h0d); edge_pin(2);
		waitev(6, 1'b1); `CHK("wake on", 1'b1, hit)
		@(posedge clk) sleep <= 1'b0;
		wreg(IDX_XCON, 8'h00);
		$display("test wake done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = '0; wdata = '0; be = 4'h1;
		pins = 4'hf; tovf = 2'b00; preq = '0; sleep = 1'b0; reti_req = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs(); t_mask(); t_prio(); t_ext(); t_soft(); t_wake();
		tally_and_finish();
	end
endmodule
bind flic_top flic_monitor flic_monitor_i (.i_clk(i_clk), .i_rst(i_rst),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
	.i_instr_last(i_instr_last), .i_instr_reti(i_instr_reti), .i_sleep(i_sleep),
	.o_call(o_call), .o_call_info(o_call_info), .o_wake(o_wake),
	.o_level_active(o_level_active));
`default_nettype wire
